// ### core/cell_afe_serial_control.v
// Purpose: serial control word, monitoring return and calibration sequencing
// Assumes: link pins sampled by mclk_i, link clock far slower than mclk_i
// Notes: analog switches are represented by control outputs only
`include "cell_afe_map.vh"

// Behaviour
// - control transfer is a 24-bit word in
// - monitoring bits shift out on same clocks
// - lowest cell bits travel first both ways
// - serial output changes on falling clock edge
// - serial input captured on rising clock edge
// - buffer offset calibration runs after power-up
// - offset calibration starts on select rise sampling
// - offset calibration lasts fixed eight milliseconds
// - analog output high impedance during calibration
// - serial shifting continues during offset calibration
// - all-zero code enters charge injection calibration
// - injection mode shorts capacitors while sampling
// - injection readout scaled by one hundred twenty-eight
// - stack code routes divided stack voltage out
// - stack divisor equals variant maximum cell count
// - stack readout valid while sampling or holding
// - hold by soft hold bit or low pin
// - route enable routes selected held cell
// - output valid after settling from select rise
// - monitoring word carries ready after power-up
module cell_afe_serial_control #(
   parameter CELLS = `MAX_CELLS,
   parameter OFFCAL_CYCLES = `OFFCAL_CYC,
   parameter STACK_SETTLE_CYCLES = `STACK_SETTLE_CYC,
   parameter CELL_SETTLE_CYCLES = `CELL_SETTLE_CYC
)(
   input wire mclk_i,
   input wire rstn_i,
   input wire sclk_i,
   input wire csn_i,
   input wire sdi_i,
   input wire external_track_input_i,
   input wire [15:0] cell_flags_i,
   input wire thermal_shutdown_i,
   output reg sdo_o,
   output reg [15:0] balance_o,
   output reg hold_o,
   output reg [3:0] cell_select_o,
   output reg cell_route_o,
   output reg stack_route_o,
   output reg [4:0] stack_divisor_o,
   output reg inject_switch_o,
   output reg inject_gain_o,
   output reg analog_output_hiz_o,
   output reg analog_output_valid_o,
   output reg offset_cal_busy_o,
   output reg diag_o,
   output reg low_power_o,
   output reg ready_o
);
   localparam [`TIMER_BITS-1:0] OFFCAL_LOAD = OFFCAL_CYCLES;
   localparam [`TIMER_BITS-1:0] STACK_LOAD = STACK_SETTLE_CYCLES;
   localparam [`TIMER_BITS-1:0] CELL_LOAD = CELL_SETTLE_CYCLES;
   localparam [4:0] DIVISOR = CELLS;

   wire sclk_s;
   wire csn_s;
   wire sdi_s;
   wire track_s;
   reg sclk_d_r;
   reg csn_d_r;
   reg pwrup_r;
   reg sdi_lat_r;
   reg [`WORD_BITS-1:0] rx_r;
   reg [`WORD_BITS-1:0] tx_r;
   reg [`WORD_BITS-1:0] ctl_r;
   reg [`WORD_BITS-1:0] tx_nxt;
   reg [`WORD_BITS-1:0] mon_w;
   reg settle_start_r;
   reg [`TIMER_BITS-1:0] settle_load_r;
   wire cal_busy;
   wire cal_done;
   wire settle_busy;
   wire settle_done;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_fall;
   wire cs_rise;
   wire [4:0] new_code;
   wire [4:0] code;
   wire new_hold;
   wire cal_start;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   // idle levels as reset values, so no false edge follows reset
   pin_sync #(
      .INIT(1'b0)
   ) u_sclk (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .pin_i(sclk_i),
      .level_o(sclk_s)
   );

   pin_sync #(
      .INIT(1'b1)
   ) u_csn (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .pin_i(csn_i),
      .level_o(csn_s)
   );

   pin_sync #(
      .INIT(1'b0)
   ) u_sdi (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .pin_i(sdi_i),
      .level_o(sdi_s)
   );

   pin_sync #(
      .INIT(1'b1)
   ) u_track (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .pin_i(external_track_input_i),
      .level_o(track_s)
   );

   assign sclk_rise = sclk_s & ~sclk_d_r & ~csn_s;
   assign sclk_fall = ~sclk_s & sclk_d_r & ~csn_s;
   assign cs_fall = ~csn_s & csn_d_r;
   assign cs_rise = csn_s & ~csn_d_r;

   // ***************************************************************
   // decode of the received word and of the applied word
   // ***************************************************************
   assign new_code = {rx_r[`CTL_SEL_LSB+3:`CTL_SEL_LSB], rx_r[`CTL_ROUTE]};
   assign code = {ctl_r[`CTL_SEL_LSB+3:`CTL_SEL_LSB], ctl_r[`CTL_ROUTE]};
   assign new_hold = rx_r[`CTL_SOFT_HOLD] | ~track_s;
   // select three is a don't care in the offset calibration code
   assign cal_start = pwrup_r | (cs_rise & ~new_hold
      & ((new_code & `CODE_OFFSET_MASK) == `CODE_OFFSET_CAL));

   always @*
   begin
      mon_w = {`WORD_BITS{1'b0}};
      mon_w[`MON_FLAG_LSB+15:`MON_FLAG_LSB] = cell_flags_i;
      mon_w[`MON_THERMAL] = thermal_shutdown_i;
      mon_w[`MON_READY] = ready_o;
      tx_nxt = {sdi_lat_r, tx_r[`WORD_BITS-1:1]};
   end

   // ***************************************************************
   // serial shifting
   // ***************************************************************
   // sdi arrives through the same sync depth as sclk, so the
   // sampled bit lines up with the detected rising edge
   always @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         sclk_d_r <= 1'b0;
         csn_d_r <= 1'b1;
      end
      else
      begin
         sclk_d_r <= sclk_s;
         csn_d_r <= csn_s;
      end
   end

   always @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         tx_r <= {`WORD_BITS{1'b0}};
         sdo_o <= 1'b0;
      end
      else if (cs_fall)
      begin
         tx_r <= mon_w;
         sdo_o <= mon_w[0];
      end
      else if (sclk_fall)
      begin
         // bits shifted in pass on after 24 clocks for daisy chains
         tx_r <= tx_nxt;
         sdo_o <= tx_nxt[0];
      end
   end

   always @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         sdi_lat_r <= 1'b0;
         rx_r <= `CTL_RESET;
      end
      else if (sclk_rise)
      begin
         sdi_lat_r <= sdi_s;
         rx_r <= {sdi_s, rx_r[`WORD_BITS-1:1]};
      end
   end

   // ***************************************************************
   // calibration and settling timers
   // ***************************************************************
   // a second start while busy restarts the full interval
   interval_timer #(
      .W(`TIMER_BITS)
   ) u_cal (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .start_i(cal_start),
      .cycles_i(OFFCAL_LOAD),
      .busy_o(cal_busy),
      .done_o(cal_done)
   );

   interval_timer #(
      .W(`TIMER_BITS)
   ) u_settle (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .start_i(settle_start_r),
      .cycles_i(settle_load_r),
      .busy_o(settle_busy),
      .done_o(settle_done)
   );

   // ***************************************************************
   // control word apply and calibration status
   // ***************************************************************
   always @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         pwrup_r <= 1'b1;
         ctl_r <= `CTL_RESET;
         settle_start_r <= 1'b0;
         settle_load_r <= CELL_LOAD;
         balance_o <= 16'h0000;
         stack_divisor_o <= DIVISOR;
         offset_cal_busy_o <= 1'b0;
         diag_o <= 1'b0;
         low_power_o <= 1'b0;
         ready_o <= 1'b0;
      end
      else
      begin
         pwrup_r <= 1'b0;
         settle_start_r <= cs_rise;
         if (cs_rise)
         begin
            ctl_r <= rx_r;
            settle_load_r <= (new_code == `CODE_STACK) ? STACK_LOAD : CELL_LOAD;
         end
         if (cal_done)
            ready_o <= 1'b1;
         offset_cal_busy_o <= cal_busy;
         balance_o <= ctl_r[`CTL_BAL_LSB+15:`CTL_BAL_LSB];
         diag_o <= ctl_r[`CTL_DIAG];
         low_power_o <= ctl_r[`CTL_LOW_POWER];
         stack_divisor_o <= DIVISOR;
      end
   end

   // ***************************************************************
   // analog routing
   // ***************************************************************
   always @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         hold_o <= 1'b0;
         cell_select_o <= 4'h0;
         cell_route_o <= 1'b0;
         stack_route_o <= 1'b0;
         inject_switch_o <= 1'b0;
         inject_gain_o <= 1'b0;
         analog_output_hiz_o <= 1'b1;
         analog_output_valid_o <= 1'b0;
      end
      else
      begin
         hold_o <= ctl_r[`CTL_SOFT_HOLD] | ~track_s;
         cell_select_o <= ctl_r[`CTL_SEL_LSB+3:`CTL_SEL_LSB];
         cell_route_o <= ~cal_busy & ctl_r[`CTL_ROUTE] & hold_o;
         // while tracking a routed cell the output shows the divided stack
         stack_route_o <= ~cal_busy & ((code == `CODE_STACK)
            | (ctl_r[`CTL_ROUTE] & ~hold_o));
         inject_switch_o <= (code == `CODE_INJECT_CAL) & ~hold_o;
         if (code == `CODE_INJECT_CAL)
            inject_gain_o <= 1'b1;
         else if (ctl_r[`CTL_ROUTE] | (code == `CODE_STACK))
            inject_gain_o <= inject_gain_o & ctl_r[`CTL_ROUTE];
         analog_output_hiz_o <= cal_busy
            | ~(ctl_r[`CTL_ROUTE] | (code == `CODE_STACK));
         if (cs_rise)
            analog_output_valid_o <= 1'b0;
         else if (settle_done & ~settle_busy)
            analog_output_valid_o <= ~cal_busy;
      end
   end
endmodule

// ### inc/cell_afe_map.vh
// Purpose: constants of the cell front-end serial control block
// Assumes: 125 MHz core clock
// Notes: field layout of the control and monitoring words
`ifndef CELL_AFE_MAP_VH
`define CELL_AFE_MAP_VH

// ***************************************************************
// word size and timing
// ***************************************************************
`define WORD_BITS 24
`define CLK_MHZ 125
`define OFFCAL_MS 8
`define OFFCAL_CYC (`OFFCAL_MS * 1000 * `CLK_MHZ)
`define STACK_SETTLE_US 60
`define STACK_SETTLE_CYC (`STACK_SETTLE_US * `CLK_MHZ)
`define CELL_SETTLE_US 8
`define CELL_SETTLE_CYC (`CELL_SETTLE_US * `CLK_MHZ)
`define TIMER_BITS 20
`define MAX_CELLS 16

// ***************************************************************
// control word fields (bit 0 shifted first)
// ***************************************************************
`define CTL_BAL_LSB 0
`define CTL_ROUTE 16
`define CTL_SEL_LSB 17
`define CTL_SOFT_HOLD 21
`define CTL_DIAG 22
`define CTL_LOW_POWER 23
`define CTL_RESET 24'h00_0000

// mode codes on {select3, select2, select1, select0, route}
`define CODE_INJECT_CAL 5'h00
`define CODE_OFFSET_CAL 5'h02
`define CODE_OFFSET_MASK 5'h0f
`define CODE_STACK 5'h18

// ***************************************************************
// monitoring word fields (bit 0 shifted first)
// ***************************************************************
`define MON_FLAG_LSB 0
`define MON_THERMAL 22
`define MON_READY 23
`endif

// ### core/pin_sync.v
// Purpose: three-flop synchroniser for pins from outside the clock domain
// Assumes: pin changes are slow against mclk_i
// Notes: output moves only when stages two and three agree
module pin_sync #(
   parameter INIT = 1'b0
)(
   input wire mclk_i,
   input wire rstn_i,
   input wire pin_i,
   output reg level_o
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   // ***************************************************************
   // stage one is read by stage two only
   // ***************************************************************
   always @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
         level_o <= INIT;
      end
      else
      begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            level_o <= s3_r;
      end
   end
endmodule

// ### core/interval_timer.v
// Purpose: down counter timing a fixed interval
// Assumes: start is a one-cycle pulse
// Notes: a new start restarts the count
module interval_timer #(
   parameter W = 20
)(
   input wire mclk_i,
   input wire rstn_i,
   input wire start_i,
   input wire [W-1:0] cycles_i,
   output reg busy_o,
   output reg done_o
);
   reg [W-1:0] cnt_r;

   // ***************************************************************
   // count
   // ***************************************************************
   always @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         cnt_r <= {W{1'b0}};
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            cnt_r <= cycles_i;
            busy_o <= 1'b1;
         end
         else if (busy_o)
         begin
            if (cnt_r <= {{(W-1){1'b0}}, 1'b1})
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            else
               cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ### tb/cell_afe_sva.sv
// Purpose: port assertions for the cell front-end serial control block
// Assumes: one clock domain, link pins slow against mclk_i
// Notes: helper counters measure settle and calibration lengths
module cell_afe_sva #(
   parameter CELLS = 16,
   parameter OFFCAL_CYCLES = 200,
   parameter CELL_SETTLE_CYCLES = 20
)(
   input wire mclk_i,
   input wire rstn_i,
   input wire sclk_i,
   input wire csn_i,
   input wire sdo_o,
   input wire [15:0] balance_o,
   input wire hold_o,
   input wire stack_route_o,
   input wire [4:0] stack_divisor_o,
   input wire inject_switch_o,
   input wire analog_output_hiz_o,
   input wire analog_output_valid_o,
   input wire offset_cal_busy_o,
   input wire ready_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // ****************
   // helper counters
   // ****************
   reg [15:0] low_cnt_r;
   reg [19:0] busy_cnt_r;
   always @(posedge mclk_i)
   begin
      if (!rstn_i)
      begin
         low_cnt_r <= 16'h0000;
         busy_cnt_r <= 20'h0_0000;
      end
      else
      begin
         low_cnt_r <= analog_output_valid_o ? 16'h0000 : low_cnt_r + 16'h0001;
         busy_cnt_r <= offset_cal_busy_o ? busy_cnt_r + 20'h0_0001 : 20'h0_0000;
      end
   end
   // ****************
   // properties
   // ****************
   // a restart mid-calibration would stretch the count, so first end only
   sequence cal_end;
      $fell(offset_cal_busy_o) && !$past(ready_o);
   endsequence
   sequence held_three;
      hold_o [*3];
   endsequence
   AST_HIZ_BUSY: assert property (offset_cal_busy_o |-> analog_output_hiz_o)
      else $error("analog output driven during calibration");
   AST_VALID_IDLE: assert property (analog_output_valid_o |-> !offset_cal_busy_o)
      else $error("output valid during calibration");
   AST_DIVISOR: assert property (stack_divisor_o == CELLS)
      else $error("stack divisor differs from cell count");
   AST_STACK_OUT: assert property (stack_route_o && !offset_cal_busy_o |-> !analog_output_hiz_o)
      else $error("stack routed but output three-stated");
   AST_CTL_APPLY: assert property (!$stable(balance_o) |-> csn_i)
      else $error("control applied inside a frame");
   AST_SDO_EDGE: assert property (!$stable(sdo_o) |-> !sclk_i && !csn_i)
      else $error("serial output moved outside a falling edge");
   AST_SETTLE: assert property ($rose(analog_output_valid_o) |-> low_cnt_r >= CELL_SETTLE_CYCLES - 2)
      else $error("output valid before settling");
   AST_READY_STICKY: assert property (ready_o |=> ready_o)
      else $error("ready flag dropped");
   AST_READY_AFTER: assert property (cal_end |-> ##[0:2] ready_o)
      else $error("ready missing after first calibration");
   AST_CAL_LEN: assert property ($fell(offset_cal_busy_o) |->
      busy_cnt_r >= OFFCAL_CYCLES - 1 && busy_cnt_r <= OFFCAL_CYCLES + 1)
      else $error("calibration length wrong");
   AST_CAL_START: assert property ($rose(offset_cal_busy_o) && ready_o |-> csn_i)
      else $error("calibration started inside a frame");
   AST_INJ_SAMPLE: assert property (held_three |-> !inject_switch_o)
      else $error("shorting switch closed while holding");
endmodule

// ### tb/link_host.sv
// Purpose: host side of the serial control link
// Assumes: 160 ns link clock, clock low between frames
// Notes: released data line shows the inverse of its last bit
module link_host (
   input wire sdo_i,
   output logic sclk_o,
   output logic csn_o,
   output logic sdi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      sclk_o = 1'b0;
      csn_o = 1'b1;
      sdi_o = 1'b0;
   end
   // ****************
   // one frame, 24 bits each way
   // ****************
   task automatic xfer(input logic [23:0] word, output logic [23:0] mon);
      int i;
      #3;
      csn_o = 1'b0;
      #160;
      for (i = 0; i < 24; i++)
      begin
         sdi_o = word[i];
         #80;
         sclk_o = 1'b1;
         mon[i] = sdo_i;
         #80;
         sclk_o = 1'b0;
      end
      #80;
      csn_o = 1'b1;
      sdi_o = ~sdi_o;
      #400;
   endtask
endmodule

// ### tb/cell_afe_serial_control_test.sv
// Purpose: self-checking bench for the cell front-end serial control block
// Assumes: shortened calibration and settle counts
// Notes: every frame also checks the returned monitoring word
module cell_afe_serial_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic external_track_input_i = 1'b1;
   logic thermal_shutdown_i = 1'b1;
   logic [15:0] cell_flags_i = 16'hA5C3;
   wire sclk_i, csn_i, sdi_i, sdo_o, hold_o, cell_route_o, stack_route_o, ready_o;
   wire inject_switch_o, inject_gain_o, analog_output_hiz_o, analog_output_valid_o;
   wire offset_cal_busy_o, diag_o, low_power_o;
   wire [15:0] balance_o;
   wire [3:0] cell_select_o;
   wire [4:0] stack_divisor_o;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   always #4 mclk_i = ~mclk_i;
   cell_afe_serial_control #(.OFFCAL_CYCLES(1000), .STACK_SETTLE_CYCLES(50),
      .CELL_SETTLE_CYCLES(20)) cell_afe_serial_control_i (.*);
   link_host link_host_i (.sdo_i(sdo_o), .sclk_o(sclk_i), .csn_o(csn_i), .sdi_o(sdi_i));
   // ****************
   // helpers
   // ****************
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [23:0] ctl(input logic [15:0] bal, input logic route,
      input logic [3:0] sel, input logic hold, input logic [1:0] mode);
      return {mode, hold, sel, route, bal};
   endfunction
   task automatic send(input logic [23:0] w);
      logic [23:0] mon;
      link_host_i.xfer(w, mon);
      check("mon", mon, 24'hC0_A5C3);
   endtask
   // which 1 waits for valid, 0 for calibration end; bounded
   task automatic await(input int which, output int n);
      n = 0;
      while (n < 1500 && (which ? analog_output_valid_o !== 1'b1 : offset_cal_busy_o !== 1'b0))
      begin
         @(negedge mclk_i);
         n++;
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_powerup;
      int n;
      repeat (4) @(negedge mclk_i);
      check("pwr", {offset_cal_busy_o, analog_output_hiz_o, ready_o}, 3'b110);
      await(0, n);
      check("pwr len", n > 984 && n < 1001, 1);
      repeat (3) @(negedge mclk_i);
      check("ready", ready_o, 1);
      $display("test powerup done");
   endtask
   task automatic t_route;
      send(ctl(16'h8001, 1'b1, 4'h5, 1'b1, 2'b01));
      check("bal", balance_o, 16'h8001);
      check("sel", cell_select_o, 4'h5);
      check("route", {cell_route_o, stack_route_o, hold_o, diag_o}, 4'hB);
      check("valid", {analog_output_valid_o, analog_output_hiz_o}, 2'b10);
      send(ctl(16'h0000, 1'b1, 4'h2, 1'b0, 2'b00));
      check("track", hold_o, 0);
      @(posedge mclk_i) external_track_input_i <= 1'b0;
      repeat (8) @(negedge mclk_i);
      check("pin hold", hold_o, 1);
      @(posedge mclk_i) external_track_input_i <= 1'b1;
      repeat (8) @(negedge mclk_i);
      check("pin track", hold_o, 0);
      $display("test route done");
   endtask
   task automatic t_inject;
      send(ctl(16'h0000, 1'b0, 4'h0, 1'b0, 2'b10));
      check("inj", {inject_switch_o, inject_gain_o, analog_output_hiz_o, low_power_o}, 4'hF);
      send(ctl(16'h0000, 1'b0, 4'h0, 1'b1, 2'b00));
      check("inj hold", {inject_switch_o, inject_gain_o}, 2'b01);
      $display("test inject done");
   endtask
   task automatic t_stack;
      int n;
      send(ctl(16'h0000, 1'b0, 4'hC, 1'b1, 2'b00));
      check("stack", {stack_route_o, analog_output_hiz_o, analog_output_valid_o}, 3'b100);
      check("div", stack_divisor_o, 5'h10);
      await(1, n);
      check("settle", n < 20, 1);
      $display("test stack done");
   endtask
   task automatic t_offcal;
      int n;
      time t0;
      send(ctl(16'h0000, 1'b0, 4'h1, 1'b1, 2'b00));
      check("no cal", offset_cal_busy_o, 0);
      send(ctl(16'h0000, 1'b0, 4'h1, 1'b0, 2'b00));
      t0 = $time;
      check("cal", {offset_cal_busy_o, analog_output_hiz_o, analog_output_valid_o}, 3'b110);
      send(ctl(16'h0000, 1'b0, 4'h8, 1'b0, 2'b00));
      check("cal run", {offset_cal_busy_o, analog_output_hiz_o}, 2'b11);
      await(0, n);
      n = int'(($time - t0) / 8) + 50;
      check("cal len", n > 985 && n < 1015, 1);
      $display("test offcal done");
   endtask
   // ****************
   // main sequence and hang guard
   // ****************
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         complete_run();
      end
   end
   initial
   begin
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      t_powerup();
      t_route();
      t_inject();
      t_stack();
      t_offcal();
      complete_run();
   end
endmodule
bind cell_afe_serial_control cell_afe_sva #(.CELLS(CELLS), .OFFCAL_CYCLES(OFFCAL_CYCLES),
   .CELL_SETTLE_CYCLES(CELL_SETTLE_CYCLES)) cell_afe_sva_i (.*);
